// ===== lcs_cfg.svh
// Constants of the limit compare and status block: timing, offsets, fields, resets
`ifndef LCS_CFG_SVH
`define LCS_CFG_SVH
// System clock rate in kHz
`define LCS_CLK_KHZ 10000
// Key and contact debounce time in ms
`define LCS_DEB_MS 10
// Half period of the peak lamp flash in ms
`define LCS_BLINK_MS 250
// Register byte offsets
`define LCS_OFS_CTRL 8'h00
`define LCS_OFS_HIGH 8'h04
`define LCS_OFS_LOW 8'h08
`define LCS_OFS_STAT 8'h0c
`define LCS_OFS_MASK 8'h10
`define LCS_OFS_STATE 8'h14
`define LCS_OFS_DVAL 8'h18
// Control register fields
`define LCS_CTRL_LOCK 0
`define LCS_CTRL_PEAK 1
// Event bits of status and mask
`define LCS_EV_HIGH 0
`define LCS_EV_LOW 1
`define LCS_EV_ADC 2
`define LCS_EV_OFL 3
`define LCS_EV_DZ 4
`define LCS_EV_HOLD 5
`define LCS_EV_COMMIT 6
`define LCS_EV_ZCAL 7
// Reset values of the limits (+19999 and -19999)
`define LCS_RST_HIGH 21'sh04e1f
`define LCS_RST_LOW 21'sh1fb1e1
// Display range bounds
`define LCS_DSP_MAX 21'sh04e1f
`define LCS_DSP_MIN 21'sh1fb1e1
// Last digit index and last setting item
`define LCS_LAST_DIGIT 3'h4
`define LCS_LAST_ITEM 2'h3
`endif

// ===== lcs_pkg.sv
// Types of the limit compare and status block
package lcs_pkg;
  // Operating mode, Gray coded along display, select, edit
  typedef enum logic [1:0] {
    LCS_DISP = 2'b00,
    LCS_SEL = 2'b01,
    LCS_EDIT = 2'b11,
    LCS_ZCAL = 2'b10
  } lcs_mode_e;
  // Signed indicated value
  typedef logic signed [20:0] lcs_val_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lcs_req_s;
  // Front status lamps
  typedef struct packed {
    logic above_upper_lamp;
    logic within_band_lamp;
    logic under_floor_lamp;
    logic peak_lamp;
    logic hold_lamp;
  } lcs_lamps_s;
  // Numeric readout and its replacement indications
  typedef struct packed {
    lcs_val_t value;
    logic adc_minus;
    logic adc_plus;
    logic negative_display_overflow;
    logic positive_display_overflow;
  } lcs_disp_s;
  // Setting progress seen by the rest of the instrument
  typedef struct packed {
    logic [1:0] item;
    logic [2:0] digit;
    logic commit;
    logic zcal_take;
  } lcs_set_s;
  // Whole state of the main module
  typedef struct packed {
    lcs_mode_e mode;
    lcs_lamps_s lamps;
    lcs_disp_s disp;
    lcs_set_s set;
    logic cal_lock;
    logic peak_mode;
    lcs_val_t hi_lim;
    lcs_val_t lo_lim;
    lcs_val_t offset;
    logic hold_on;
    lcs_val_t held;
    logic [7:0] status;
    logic [7:0] mask;
    logic [31:0] rdata;
  } lcs_state_s;
endpackage : lcs_pkg

// ===== lcs_debounce.sv
// Debounce of key and contact inputs with a press pulse per input
`timescale 1ns/1ps
`default_nettype none
module lcs_debounce #(
  parameter int N = 5,
  parameter int DEB_CYC = 100000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Raw levels and press pulses
  input wire logic [N-1:0] raw_in,
  output logic [N-1:0] press
);
  import lcs_pkg::*;
  localparam int CW = $clog2(DEB_CYC + 1);
  // Per input state
  typedef struct packed {
    logic stable;
    logic [CW-1:0] cnt;
    logic press;
  } lcs_deb_s;
  lcs_deb_s st_r [N];
  lcs_deb_s st_nxt [N];
  for (genvar g = 0; g < N; g++) begin : g_ch
    // A change must hold for the whole window before it counts
    always_comb begin
      st_nxt[g] = st_r[g];
      st_nxt[g].press = 1'b0;
      if (raw_in[g] == st_r[g].stable) begin
        st_nxt[g].cnt = '0;
      end else if (st_r[g].cnt == CW'(DEB_CYC - 1)) begin
        st_nxt[g].cnt = '0;
        st_nxt[g].stable = raw_in[g];
        st_nxt[g].press = raw_in[g];
      end else begin
        st_nxt[g].cnt = st_r[g].cnt + 1'b1;
      end
      if (srst) begin
        st_nxt[g] = '0;
      end
    end
    // State register
    always_ff @(posedge sys_clk) begin
      st_r[g] <= st_nxt[g];
    end
    assign press[g] = st_r[g].press;
  end
endmodule : lcs_debounce
`default_nettype wire

// ===== lcs_blink.sv
// Flash phase divider for the peak lamp
`timescale 1ns/1ps
`default_nettype none
module lcs_blink #(
  parameter int BLINK_CYC = 2500000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Flash phase, toggles every half period
  output logic phase
);
  import lcs_pkg::*;
  localparam int CW = $clog2(BLINK_CYC + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic phase;
  } lcs_blk_s;
  lcs_blk_s st_r;
  lcs_blk_s st_nxt;
  // Divider with toggle at the end of each half period
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt == CW'(BLINK_CYC - 1)) begin
      st_nxt.cnt = '0;
      st_nxt.phase = ~st_r.phase;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
    if (srst) begin
      st_nxt = '0;
    end
  end
  // State register
  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end
  assign phase = st_r.phase;
endmodule : lcs_blink
`default_nettype wire

// ===== lcs_top.sv
// Limit comparison, overflow display, key handling and status registers
`include "lcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Above high limit: upper lamp, high relay
// - Within band lamp, both bounds inclusive
// - Below low limit: floor lamp, low relay
// - Peak lamp flashes while peak hold
// - Hold lamp lit while value held
// - ADC minus overrange replaces readout
// - ADC plus overrange replaces readout
// - Below -19999 shows negative overflow
// - Above 19999 shows positive overflow
// - Zero key, lock off: zero calibration
// - Zero key, lock on: digital zero
// - Setting: zero key selects, steps digit
// - Display: hold key toggles hold
// - Setting: hold key confirms and commits
// - Zero contact acts only when locked
// - Relays normally open, closed when active
module lcs_top #(
  parameter int DEB_CYC = `LCS_DEB_MS * `LCS_CLK_KHZ,
  parameter int BLINK_CYC = `LCS_BLINK_MS * `LCS_CLK_KHZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire lcs_pkg::lcs_req_s bus_req,
  output logic [31:0] bus_rdata,
  // Measurement from the converter path
  input wire logic signed [19:0] meas_raw,
  input wire logic meas_valid,
  input wire logic adc_ovr_pos,
  input wire logic adc_ovr_neg,
  // Front keys and external contacts
  input wire logic zero_key,
  input wire logic hold_key,
  input wire logic set_key,
  input wire logic hold_input,
  input wire logic digital_zero_input,
  // Lamps, relays and readout
  output lcs_pkg::lcs_lamps_s lamps,
  output logic relay_hi,
  output logic relay_lo,
  output lcs_pkg::lcs_disp_s disp,
  // Mode and setting progress
  output lcs_pkg::lcs_mode_e op_mode,
  output lcs_pkg::lcs_set_s setting,
  // Interrupt
  output logic irq
);
  import lcs_pkg::*;

  lcs_state_s st_r; // Registered state
  lcs_state_s st_nxt; // Next state
  logic [4:0] press; // Debounced press pulses
  logic blink; // Flash phase
  logic p_zero, p_hold, p_set, p_hin, p_dz; // Named press pulses
  lcs_val_t raw_ext; // Raw value widened to the value width
  lcs_val_t ind_now; // Live indicated value after digital zero
  lcs_val_t cmp_val; // Value shown and compared
  logic adc_any; // Either converter overrange
  logic [7:0] ev; // Events of this cycle
  logic hold_tgl; // Hold toggle request
  logic do_dz; // Digital zero request

  // Keys and contacts share one debouncer
  lcs_debounce #(
    .N(5),
    .DEB_CYC(DEB_CYC)
  ) u_deb (
    .sys_clk(sys_clk),
    .srst(srst),
    .raw_in({digital_zero_input, hold_input, set_key, hold_key, zero_key}),
    .press(press)
  );

  // Peak lamp flash source
  lcs_blink #(
    .BLINK_CYC(BLINK_CYC)
  ) u_blink (
    .sys_clk(sys_clk),
    .srst(srst),
    .phase(blink)
  );

  assign p_zero = press[0];
  assign p_hold = press[1];
  assign p_set = press[2];
  assign p_hin = press[3];
  assign p_dz = press[4];

  // Live and displayed values
  assign raw_ext = {meas_raw[19], meas_raw};
  assign ind_now = raw_ext - st_r.offset;
  assign cmp_val = st_r.hold_on ? st_r.held : ind_now;
  assign adc_any = adc_ovr_pos | adc_ovr_neg;

  // Next state: keys, hold, measurement update, registers
  always_comb begin
    st_nxt = st_r;
    ev = '0;
    hold_tgl = 1'b0;
    do_dz = 1'b0;
    st_nxt.set.commit = 1'b0;
    st_nxt.set.zcal_take = 1'b0;
    // Mode handling; the set key always wins over the other keys
    unique case (st_r.mode)
      LCS_DISP: begin
        if (p_set) begin
          st_nxt.mode = LCS_SEL;
          st_nxt.set.item = '0;
          st_nxt.set.digit = '0;
        end else begin
          if (p_zero) begin
            if (st_r.cal_lock) begin
              do_dz = 1'b1;
            end else begin
              st_nxt.mode = LCS_ZCAL;
            end
          end
          // The contact only counts under calibration lock
          if (p_dz && st_r.cal_lock) begin
            do_dz = 1'b1;
          end
          hold_tgl = p_hold | p_hin;
        end
      end
      LCS_SEL: begin
        if (p_set) begin
          st_nxt.mode = LCS_DISP;
        end else if (p_zero) begin
          st_nxt.set.item = st_r.set.item + 2'h1;
        end else if (p_hold) begin
          st_nxt.mode = LCS_EDIT;
          st_nxt.set.digit = '0;
        end
      end
      LCS_EDIT: begin
        if (p_set) begin
          st_nxt.mode = LCS_DISP;
        end else if (p_zero) begin
          // Flashing digit walks and wraps over five places
          if (st_r.set.digit == `LCS_LAST_DIGIT) begin
            st_nxt.set.digit = '0;
          end else begin
            st_nxt.set.digit = st_r.set.digit + 3'h1;
          end
        end else if (p_hold) begin
          st_nxt.set.commit = 1'b1;
          st_nxt.mode = LCS_DISP;
          ev[`LCS_EV_COMMIT] = 1'b1;
        end
      end
      LCS_ZCAL: begin
        if (p_set) begin
          st_nxt.mode = LCS_DISP;
        end else if (p_hold) begin
          st_nxt.set.zcal_take = 1'b1;
          st_nxt.mode = LCS_DISP;
          ev[`LCS_EV_ZCAL] = 1'b1;
        end
      end
    endcase

    // Digital zero takes the present raw value as the new zero
    if (do_dz) begin
      st_nxt.offset = raw_ext;
      ev[`LCS_EV_DZ] = 1'b1;
    end

    // Hold toggle; a start freezes the live value
    if (hold_tgl) begin
      st_nxt.hold_on = ~st_r.hold_on;
      st_nxt.held = ind_now;
      ev[`LCS_EV_HOLD] = 1'b1;
    end else if (st_r.hold_on && st_r.peak_mode && meas_valid && !adc_any) begin
      // Peak hold follows new maxima only
      if (ind_now > st_r.held) begin
        st_nxt.held = ind_now;
      end
    end

    // Lamps that follow the hold state every cycle
    st_nxt.lamps.peak_lamp = st_r.hold_on & st_r.peak_mode & blink;
    st_nxt.lamps.hold_lamp = st_r.hold_on;

    // Compare and readout move only on a new measurement, so a
    // limit change takes effect with the next conversion
    if (meas_valid) begin
      // Overrange counts as beyond the matching limit
      st_nxt.lamps.above_upper_lamp = adc_ovr_pos |
        (!adc_ovr_neg && (cmp_val > st_r.hi_lim));
      st_nxt.lamps.under_floor_lamp = adc_ovr_neg |
        (!adc_ovr_pos && (cmp_val < st_r.lo_lim));
      st_nxt.lamps.within_band_lamp = !adc_any &&
        (cmp_val >= st_r.lo_lim) && (cmp_val <= st_r.hi_lim);
      st_nxt.disp.adc_minus = adc_ovr_neg;
      st_nxt.disp.adc_plus = adc_ovr_pos & ~adc_ovr_neg;
      st_nxt.disp.negative_display_overflow =
        !adc_any && (cmp_val < `LCS_DSP_MIN);
      st_nxt.disp.positive_display_overflow =
        !adc_any && (cmp_val > `LCS_DSP_MAX);
      // Any indication replaces the number, which then reads zero
      if (adc_any || (cmp_val < `LCS_DSP_MIN) || (cmp_val > `LCS_DSP_MAX)) begin
        st_nxt.disp.value = '0;
      end else begin
        st_nxt.disp.value = cmp_val;
      end
      ev[`LCS_EV_HIGH] = st_nxt.lamps.above_upper_lamp & ~st_r.lamps.above_upper_lamp;
      ev[`LCS_EV_LOW] = st_nxt.lamps.under_floor_lamp & ~st_r.lamps.under_floor_lamp;
      ev[`LCS_EV_ADC] = adc_any;
      ev[`LCS_EV_OFL] = st_nxt.disp.negative_display_overflow |
        st_nxt.disp.positive_display_overflow;
    end

    // Register writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `LCS_OFS_CTRL: begin
          st_nxt.cal_lock = bus_req.wdata[`LCS_CTRL_LOCK];
          st_nxt.peak_mode = bus_req.wdata[`LCS_CTRL_PEAK];
        end
        `LCS_OFS_HIGH: st_nxt.hi_lim = bus_req.wdata[20:0];
        `LCS_OFS_LOW: st_nxt.lo_lim = bus_req.wdata[20:0];
        `LCS_OFS_MASK: st_nxt.mask = bus_req.wdata[7:0];
        default: ; // Read only or unmapped: ignored
      endcase
    end

    // Register reads; data stand only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `LCS_OFS_CTRL: st_nxt.rdata = {30'h0, st_r.peak_mode, st_r.cal_lock};
        `LCS_OFS_HIGH: st_nxt.rdata = {11'h0, st_r.hi_lim};
        `LCS_OFS_LOW: st_nxt.rdata = {11'h0, st_r.lo_lim};
        `LCS_OFS_STAT: st_nxt.rdata = {24'h0, st_r.status};
        `LCS_OFS_MASK: st_nxt.rdata = {24'h0, st_r.mask};
        `LCS_OFS_STATE: st_nxt.rdata = {15'h0, st_r.disp.adc_minus, st_r.disp.adc_plus,
          st_r.disp.negative_display_overflow, st_r.disp.positive_display_overflow,
          st_r.set.digit, st_r.set.item, st_r.hold_on, st_r.mode, st_r.lamps};
        `LCS_OFS_DVAL: st_nxt.rdata = {11'h0, st_r.disp.value};
        default: st_nxt.rdata = '0; // Unmapped reads zero
      endcase
    end

    // Status is sticky; a read clears it but a new event survives
    if (bus_req.rd && (bus_req.addr == `LCS_OFS_STAT)) begin
      st_nxt.status = ev;
    end else begin
      st_nxt.status = st_r.status | ev;
    end

    // Synchronous reset
    if (srst) begin
      st_nxt = '0;
      st_nxt.mode = LCS_DISP;
      st_nxt.hi_lim = `LCS_RST_HIGH;
      st_nxt.lo_lim = `LCS_RST_LOW;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end

  // Outputs; relays close only while their lamp condition holds
  assign lamps = st_r.lamps;
  assign relay_hi = st_r.lamps.above_upper_lamp;
  assign relay_lo = st_r.lamps.under_floor_lamp;
  assign disp = st_r.disp;
  assign op_mode = st_r.mode;
  assign setting = st_r.set;
  assign bus_rdata = st_r.rdata;
  assign irq = |(st_r.status & st_r.mask);

  // Checks on the lamp, display and key behaviour
  hi_lamp_a: assert property (@(posedge sys_clk) disable iff (srst)
    (meas_valid && !adc_any && cmp_val > st_r.hi_lim) |=> (lamps.above_upper_lamp && relay_hi))
    else $error("upper lamp or high relay missing");
  band_lamp_a: assert property (@(posedge sys_clk) disable iff (srst)
    (meas_valid && !adc_any && cmp_val >= st_r.lo_lim && cmp_val <= st_r.hi_lim)
    |=> lamps.within_band_lamp)
    else $error("band lamp missing");
  low_lamp_a: assert property (@(posedge sys_clk) disable iff (srst)
    (meas_valid && !adc_any && cmp_val < st_r.lo_lim) |=> (lamps.under_floor_lamp && relay_lo))
    else $error("floor lamp or low relay missing");
  peak_flash_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!st_r.hold_on || !st_r.peak_mode) |=> !lamps.peak_lamp)
    else $error("peak lamp lit without peak hold");
  hold_lamp_a: assert property (@(posedge sys_clk) disable iff (srst)
    hold_tgl |=> ##1 (lamps.hold_lamp != $past(lamps.hold_lamp, 2)))
    else $error("hold lamp did not follow hold");
  adc_minus_a: assert property (@(posedge sys_clk) disable iff (srst)
    (meas_valid && adc_ovr_neg) |=> (disp.adc_minus && disp.value == '0))
    else $error("minus overrange not shown");
  adc_plus_a: assert property (@(posedge sys_clk) disable iff (srst)
    (meas_valid && adc_ovr_pos && !adc_ovr_neg) |=> (disp.adc_plus && disp.value == '0))
    else $error("plus overrange not shown");
  neg_ofl_a: assert property (@(posedge sys_clk) disable iff (srst)
    (meas_valid && !adc_any && cmp_val < `LCS_DSP_MIN)
    |=> (disp.negative_display_overflow && disp.value == '0))
    else $error("negative overflow not shown");
  pos_ofl_a: assert property (@(posedge sys_clk) disable iff (srst)
    (meas_valid && !adc_any && cmp_val > `LCS_DSP_MAX)
    |=> (disp.positive_display_overflow && disp.value == '0))
    else $error("positive overflow not shown");
  zcal_entry_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r.mode == LCS_DISP && p_zero && !p_set && !st_r.cal_lock) |=> op_mode == LCS_ZCAL)
    else $error("zero calibration not entered");
  dig_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r.mode == LCS_DISP && p_zero && !p_set && st_r.cal_lock)
    |=> (st_r.offset == $past(raw_ext) && ind_now == lcs_val_t'(raw_ext - $past(raw_ext))))
    else $error("digital zero not applied");
  digit_wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r.mode == LCS_EDIT && p_zero && !p_set && st_r.set.digit == `LCS_LAST_DIGIT)
    |=> setting.digit == 3'h0)
    else $error("flashing digit did not wrap");
  hold_key_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r.mode == LCS_DISP && !p_set && p_hold) |=> st_r.hold_on != $past(st_r.hold_on))
    else $error("hold key did not toggle hold");
  commit_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r.mode == LCS_EDIT && !p_set && !p_zero && p_hold)
    |=> (setting.commit && op_mode == LCS_DISP) ##1 !setting.commit)
    else $error("commit pulse wrong");
  dz_ignore_a: assert property (@(posedge sys_clk) disable iff (srst)
    (p_dz && !p_zero && !st_r.cal_lock) |=> $stable(st_r.offset))
    else $error("zero contact acted without lock");
  hold_contact_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r.mode == LCS_DISP && !p_set && p_hin) |=> st_r.hold_on != $past(st_r.hold_on))
    else $error("hold contact did not toggle hold");
  zcal_take_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r.mode == LCS_ZCAL && !p_set && p_hold)
    |=> (setting.zcal_take && op_mode == LCS_DISP))
    else $error("zero calibration take pulse missing");
endmodule : lcs_top
`default_nettype wire

// ===== lcs_panel.sv
// Operator panel model: front keys, contact inputs and relay loads
`timescale 1ns/1ps
`default_nettype none
module lcs_panel #(
  parameter int PRESS_CYC = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Press command from the bench, one bit a key
  input wire logic [4:0] press_req,
  output logic [4:0] keys,
  output logic busy,
  // Relay coils and the loads they switch
  input wire logic relay_hi,
  input wire logic relay_lo,
  output logic load_hi_on,
  output logic load_lo_on
);
  // Cycle count inside one press and release
  int cnt;
  // Press held, then released long enough for the next press to count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      keys <= 5'h00;
      busy <= 1'b0;
      cnt <= 0;
    end else if (!busy && press_req != 5'h00) begin
      keys <= press_req;
      busy <= 1'b1;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == PRESS_CYC - 1) begin
        keys <= 5'h00;
      end
      if (cnt == 2 * PRESS_CYC - 1) begin
        busy <= 1'b0;
      end
    end
  end
  // Normally open contacts: a load sees power only while its coil is driven
  assign load_hi_on = relay_hi;
  assign load_lo_on = relay_lo;
endmodule : lcs_panel
`default_nettype wire

// ===== testbench.sv
// Self-checking bench of the limit compare and status block
`include "lcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lcs_pkg::*;
  // Clock, reset and design ports
  logic sys_clk, srst, meas_valid, adc_ovr_pos, adc_ovr_neg;
  logic relay_hi, relay_lo, irq, busy, load_hi_on, load_lo_on;
  lcs_req_s bus_req;
  logic [31:0] bus_rdata;
  logic signed [19:0] meas_raw;
  logic [4:0] keys, press_req;
  lcs_lamps_s lamps;
  lcs_disp_s disp;
  lcs_mode_e op_mode;
  lcs_set_s setting;
  int failures, comparisons;
  // Short counts keep debounce and flash within a few cycles
  lcs_top #(.DEB_CYC(4), .BLINK_CYC(4)) dut (.sys_clk(sys_clk), .srst(srst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .meas_raw(meas_raw),
    .meas_valid(meas_valid), .adc_ovr_pos(adc_ovr_pos), .adc_ovr_neg(adc_ovr_neg),
    .zero_key(keys[4]), .hold_key(keys[3]), .set_key(keys[2]),
    .hold_input(keys[1]), .digital_zero_input(keys[0]), .lamps(lamps),
    .relay_hi(relay_hi), .relay_lo(relay_lo), .disp(disp), .op_mode(op_mode),
    .setting(setting), .irq(irq));
  // Press length leaves debounce slack on both edges
  lcs_panel #(.PRESS_CYC(8)) panel (.sys_clk(sys_clk), .srst(srst),
    .press_req(press_req), .keys(keys), .busy(busy), .relay_hi(relay_hi),
    .relay_lo(relay_lo), .load_hi_on(load_hi_on), .load_lo_on(load_lo_on));
  // Clock of 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict and end of run
  task close_out();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus_req <= '0;
    #1;
  endtask : wr
  // One-cycle read, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk) bus_req <= '0;
    #1 d = bus_rdata;
  endtask : rd
  // One measurement pulse, outputs looked at once they have landed
  task automatic meas(input int v, input logic p, input logic n);
    @(posedge sys_clk) begin
      meas_raw <= 20'(v);
      meas_valid <= 1'b1;
      adc_ovr_pos <= p;
      adc_ovr_neg <= n;
    end
    @(posedge sys_clk) meas_valid <= 1'b0;
    @(posedge sys_clk) #1;
  endtask : meas
  // Hand one press to the panel and wait, bounded, for its release
  task automatic press(input logic [4:0] k);
    int i;
    @(posedge sys_clk) press_req <= k;
    @(posedge sys_clk) press_req <= 5'h00;
    #1;
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(posedge sys_clk) #1;
  endtask : press
  // Limit reset values and an unmapped read
  task t_reset();
    logic [31:0] d;
    rd(`LCS_OFS_HIGH, d);
    chk(d, 32'h0004e1f);
    rd(`LCS_OFS_LOW, d);
    chk(d, 32'h001fb1e1);
    rd(8'h40, d);
    chk(d, 32'h0);
    chk({30'h0, op_mode}, {30'h0, LCS_DISP});
    $display("done reset");
  endtask : t_reset
  // Band edges, relays, sticky events, mask and interrupt
  task t_limits();
    int v[4] = '{101, 100, -100, -101};
    logic [4:0] e[4] = '{5'b10000, 5'b01000, 5'b01000, 5'b00100};
    logic [31:0] d;
    wr(`LCS_OFS_HIGH, 32'h64);
    wr(`LCS_OFS_LOW, 32'h001fff9c);
    for (int i = 0; i < 4; i++) begin
      meas(v[i], 1'b0, 1'b0);
      chk({27'h0, lamps}, {27'h0, e[i]});
      chk({relay_hi, relay_lo, load_hi_on, load_lo_on}, {e[i][4], e[i][2], e[i][4], e[i][2]});
    end
    chk({31'h0, irq}, 32'h0);
    wr(`LCS_OFS_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(`LCS_OFS_STAT, d);
    chk(d, 32'h3);
    chk({31'h0, irq}, 32'h0);
    $display("done limits");
  endtask : t_limits
  // Display overflow bounds and converter overrange
  task t_ovf();
    int v[4] = '{20000, 19999, -19999, -20000};
    logic [3:0] e[4] = '{4'b0001, 4'b0000, 4'b0000, 4'b0010};
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      meas(v[i], 1'b0, 1'b0);
      chk({28'h0, disp[3:0]}, {28'h0, e[i]});
    end
    meas(0, 1'b1, 1'b0);
    chk({28'h0, disp[3:0]}, 32'h4);
    meas(0, 1'b0, 1'b1);
    chk({28'h0, disp[3:0]}, 32'h8);
    rd(`LCS_OFS_STATE, d);
    chk(d, 32'h00010004);
    $display("done overflow");
  endtask : t_ovf
  // Hold toggled by key and by contact, peak lamp flashing meanwhile
  task t_hold();
    logic hi, lo;
    logic [31:0] d;
    hi = 1'b0;
    lo = 1'b0;
    wr(`LCS_OFS_CTRL, 32'h2);
    press(5'b01000);
    chk({31'h0, lamps.hold_lamp}, 32'h1);
    repeat (12) @(posedge sys_clk) begin
      #1;
      if (lamps.peak_lamp === 1'b1) hi = 1'b1;
      if (lamps.peak_lamp === 1'b0) lo = 1'b1;
    end
    chk({30'h0, hi, lo}, 32'h3);
    press(5'b00010);
    chk({30'h0, lamps.hold_lamp, lamps.peak_lamp}, 32'h0);
    rd(`LCS_OFS_STAT, d);
    chk({31'h0, d[5]}, 32'h1);
    $display("done hold");
  endtask : t_hold
  // Zero key and zero contact with calibration lock off and on
  task t_zero();
    logic [31:0] d;
    wr(`LCS_OFS_CTRL, 32'h0);
    press(5'b10000);
    chk({30'h0, op_mode}, {30'h0, LCS_ZCAL});
    press(5'b01000);
    chk({30'h0, op_mode}, {30'h0, LCS_DISP});
    rd(`LCS_OFS_STAT, d);
    chk({31'h0, d[7]}, 32'h1);
    meas(50, 1'b0, 1'b0);
    press(5'b00001);
    meas(50, 1'b0, 1'b0);
    chk({11'h0, disp.value}, 32'd50);
    wr(`LCS_OFS_CTRL, 32'h1);
    press(5'b10000);
    meas(50, 1'b0, 1'b0);
    chk({11'h0, disp.value}, 32'd0);
    meas(80, 1'b0, 1'b0);
    chk({11'h0, disp.value}, 32'd30);
    rd(`LCS_OFS_DVAL, d);
    chk(d, 32'd30);
    press(5'b00001);
    meas(80, 1'b0, 1'b0);
    chk({11'h0, disp.value}, 32'd0);
    $display("done zero");
  endtask : t_zero
  // Setting walk: item and digit stepping, confirm and commit
  task t_set();
    logic [31:0] d;
    press(5'b00100);
    chk({30'h0, op_mode}, {30'h0, LCS_SEL});
    press(5'b10000);
    chk({30'h0, setting.item}, 32'h1);
    press(5'b01000);
    chk({27'h0, op_mode, setting.digit}, {27'h0, LCS_EDIT, 3'h0});
    press(5'b10000);
    chk({29'h0, setting.digit}, 32'h1);
    press(5'b01000);
    chk({30'h0, op_mode}, {30'h0, LCS_DISP});
    rd(`LCS_OFS_STAT, d);
    chk({31'h0, d[6]}, 32'h1);
    $display("done setting");
  endtask : t_set
  // Main sequence
  initial begin
    failures = 0;
    comparisons = 0;
    srst = 1'b1;
    bus_req = '0;
    meas_raw = 20'h0;
    meas_valid = 1'b0;
    adc_ovr_pos = 1'b0;
    adc_ovr_neg = 1'b0;
    press_req = 5'h00;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_limits();
    t_ovf();
    t_hold();
    t_zero();
    t_set();
    close_out();
  end
  // Watchdog: the tests need about three hundred and twenty cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
